// ==== common/tsa_defines.svh ====
/*
 * Register indices, field positions, reset values and timing counts of the
 * temperature threshold alert block.
 * Assumes a 20 MHz device clock and a byte-wide register port.
 */
`ifndef TSA_DEFINES_SVH
`define TSA_DEFINES_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define TSA_IDX_TEMP        2'h0
`define TSA_IDX_CONFIG      2'h1
`define TSA_IDX_LOWER       2'h2
`define TSA_IDX_UPPER       2'h3

// ****************************************************************
// Configuration word field positions
// ****************************************************************
`define TSA_CFG_AL          5
`define TSA_CFG_CR_LO       6
`define TSA_CFG_SM          8
`define TSA_CFG_IM          9
`define TSA_CFG_POL         10
`define TSA_CFG_CF_LO       11
`define TSA_CFG_RSVD_ONE    14
`define TSA_CFG_SS          15

// ****************************************************************
// Reset values and limit write mask
// ****************************************************************
`define TSA_LOWER_RST       16'h2580
`define TSA_UPPER_RST       16'h2800
`define TSA_LIMIT_MASK      16'hfff0
`define TSA_CR_RST          2'h2
`define TSA_TEMP_RST        16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define TSA_CLK_HZ          20000000
`define TSA_BASE_PERIOD_MS  125
`define TSA_BASE_PERIOD_CYC (`TSA_BASE_PERIOD_MS * (`TSA_CLK_HZ / 1000))

`endif

// ==== common/tsa_pkg.sv ====
/*
 * Types shared by the temperature threshold alert block.
 * Assumes tsa_defines.svh supplies all numeric constants.
 */
package tsa_pkg;

    typedef enum logic [1:0] {
        PH_WATCH_HIGH = 2'b00,
        PH_HOLD_HIGH  = 2'b01,
        PH_WATCH_LOW  = 2'b10,
        PH_HOLD_LOW   = 2'b11
    } alert_phase_t;

    typedef struct packed {
        logic [1:0] fault_count_field;
        logic       alert_level_select;
        logic       latch_mode_sel;
        logic       sleep_select;
        logic [1:0] conv_rate;
    } cfg_t;

    typedef struct packed {
        cfg_t         cfg;
        logic [15:0]  temp;
        logic [15:0]  lower;
        logic [15:0]  upper;
        logic [1:0]   idx;
        logic         phase_lo;
        logic [7:0]   wr_hold;
        logic [7:0]   rd_hold;
        logic [7:0]   rd_data;
        logic         conv_run;
        logic         conv_single;
        logic         conv_long;
        logic         sleep_fresh;
        logic [31:0]  timer;
        alert_phase_t ph;
        logic         alert_pin;
    } core_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sync_t;

    typedef struct packed {
        logic [1:0] cnt;
    } fc_t;

endpackage : tsa_pkg

// ==== hdl/sync_edge.sv ====
/*
 * Two-flop synchroniser with rising edge detect.
 * Assumes the input is a level from outside the CLK domain.
 */
`timescale 1ns/10ps
module sync_edge
    import tsa_pkg::*;
(
    input  wire logic CLK,
    input  wire logic RESET_N,
    input  wire logic ASYNC_IN,
    output logic      LEVEL,
    output logic      RISE
);
    sync_t r;
    sync_t n;

    always_comb begin
        n    = r;
        n.s1 = ASYNC_IN;
        n.s2 = r.s1;
        n.s3 = r.s2;
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign LEVEL = r.s2;
    assign RISE  = r.s2 & ~r.s3;
endmodule : sync_edge

// ==== hdl/fault_counter.sv ====
/*
 * Consecutive qualifying-conversion counter.
 * Assumes EVAL is a one-cycle pulse per completed conversion.
 */
`timescale 1ns/10ps
module fault_counter
    import tsa_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RESET_N,
    input  wire logic       EVAL,
    input  wire logic       HIT,
    input  wire logic       RESTART,
    input  wire logic [1:0] CF,
    output logic            FIRE
);
    fc_t r;
    fc_t n;

    // Count holds prior hits, so code k needs k+1 in a row
    assign FIRE = EVAL & HIT & (r.cnt == CF);

    always_comb begin
        n = r;
        if (RESTART) begin
            n.cnt = 2'h0;
        end else if (EVAL) begin
            if (!HIT || FIRE) begin
                n.cnt = 2'h0;
            end else begin
                n.cnt = r.cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    property p_fire_count;
        @(posedge CLK) disable iff (!RESET_N)
        (EVAL && HIT && !RESTART && r.cnt != CF) |=> (r.cnt == $past(r.cnt) + 2'h1);
    endproperty
    a_fire_count: assert property (p_fire_count) else $error("fault count did not advance");
endmodule : fault_counter

// ==== hdl/temp_threshold_alert.sv ====
/*
 * Digital back end of a temperature sensor: result and limit registers,
 * continuous and single-shot conversion control, and the alert engine.
 * Assumes a serial slave engine on CLK delivers index writes and byte
 * strobes, and an analog converter reports completion on an async level.
 */
`timescale 1ns/10ps
`include "tsa_defines.svh"
module temp_threshold_alert
    import tsa_pkg::*;
#(
    parameter int unsigned BASE_PERIOD_CYC = `TSA_BASE_PERIOD_CYC
)(
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        IDX_WR,
    input  wire logic [1:0]  IDX_DATA,
    input  wire logic        XFER_START,
    input  wire logic        WR_STB,
    input  wire logic [7:0]  WR_DATA,
    input  wire logic        RD_STB,
    output logic      [7:0]  RD_DATA,
    input  wire logic        CONV_DONE,
    input  wire logic [15:0] CONV_RESULT,
    output logic             CONV_RUN,
    output logic             CONV_LONG,
    output logic             ALERT
);

    // ****************************************************************
    // State and reset image
    // ****************************************************************
    localparam core_t CORE_RST = '{
        cfg:         '{fault_count_field: 2'h0, alert_level_select: 1'b0,
                       latch_mode_sel: 1'b0, sleep_select: 1'b0,
                       conv_rate: `TSA_CR_RST},
        temp:        `TSA_TEMP_RST,
        lower:       `TSA_LOWER_RST,
        upper:       `TSA_UPPER_RST,
        idx:         `TSA_IDX_TEMP,
        phase_lo:    1'b0,
        wr_hold:     8'h00,
        rd_hold:     8'h00,
        rd_data:     8'h00,
        conv_run:    1'b0,
        conv_single: 1'b0,
        conv_long:   1'b0,
        sleep_fresh: 1'b0,
        timer:       32'h0000_0000,
        ph:          PH_WATCH_HIGH,
        alert_pin:   1'b1
    };

    core_t        r;
    core_t        n;
    logic         done_rise;
    logic         eval;
    logic         hit;
    logic         fire;
    logic         restart;
    logic [15:0]  word_wr;
    logic [15:0]  word_rd;
    logic         cfg_commit;
    logic [31:0]  base_c;
    logic [31:0]  period;
    logic         active_r;

    sync_edge u_done_sync (
        .CLK      (CLK),
        .RESET_N  (RESET_N),
        .ASYNC_IN (CONV_DONE),
        .LEVEL    (),
        .RISE     (done_rise)
    );

    // ****************************************************************
    // Conversion result qualification
    // ****************************************************************
    // Result is bundled data: stable before the done level, sampled
    // only after that level has crossed through two flops
    assign eval     = done_rise & r.conv_run;
    assign active_r = (r.ph == PH_HOLD_HIGH) || (r.ph == PH_HOLD_LOW);
    assign word_wr  = {r.wr_hold, WR_DATA};
    assign cfg_commit = WR_STB && !IDX_WR && !XFER_START && r.phase_lo
                        && (r.idx == `TSA_IDX_CONFIG);

    always_comb begin
        hit = 1'b0;
        case (r.ph)
            PH_WATCH_HIGH: hit = $signed(CONV_RESULT) >= $signed(r.upper);
            PH_HOLD_HIGH:  hit = !r.cfg.latch_mode_sel
                                 && ($signed(CONV_RESULT) <= $signed(r.lower));
            PH_WATCH_LOW:  hit = $signed(CONV_RESULT) < $signed(r.lower);
            PH_HOLD_LOW:   hit = 1'b0;
            default:       hit = 1'b0;
        endcase
    end

    fault_counter u_faults (
        .CLK     (CLK),
        .RESET_N (RESET_N),
        .EVAL    (eval),
        .HIT     (hit),
        .RESTART (restart),
        .CF      (r.cfg.fault_count_field),
        .FIRE    (fire)
    );

    assign restart = (n.ph != r.ph);

    // ****************************************************************
    // Continuous conversion period
    // ****************************************************************
    assign base_c = BASE_PERIOD_CYC;
    always_comb begin
        case (r.cfg.conv_rate)
            2'h0:    period = base_c << 5;
            2'h1:    period = base_c << 3;
            2'h2:    period = base_c << 1;
            2'h3:    period = base_c;
            default: period = base_c;
        endcase
    end

    // ****************************************************************
    // Register read word
    // ****************************************************************
    always_comb begin
        word_rd = 16'h0000;
        case (r.idx)
            `TSA_IDX_TEMP: word_rd = r.temp;
            `TSA_IDX_CONFIG: begin
                word_rd[`TSA_CFG_SS]                    = r.conv_single;
                word_rd[`TSA_CFG_RSVD_ONE]              = 1'b1;
                word_rd[`TSA_CFG_CF_LO+1:`TSA_CFG_CF_LO] = r.cfg.fault_count_field;
                word_rd[`TSA_CFG_POL]                   = r.cfg.alert_level_select;
                word_rd[`TSA_CFG_IM]                    = r.cfg.latch_mode_sel;
                word_rd[`TSA_CFG_SM]                    = r.cfg.sleep_select;
                word_rd[`TSA_CFG_CR_LO+1:`TSA_CFG_CR_LO] = r.cfg.conv_rate;
                word_rd[`TSA_CFG_AL]                    = r.alert_pin;
            end
            `TSA_IDX_LOWER: word_rd = r.lower;
            `TSA_IDX_UPPER: word_rd = r.upper;
            default: word_rd = 16'h0000;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        n = r;
        // Conversion completion
        if (eval) begin
            n.temp        = CONV_RESULT;
            n.conv_run    = 1'b0;
            n.conv_single = 1'b0;
            n.conv_long   = 1'b0;
        end
        // Continuous mode pacing; a busy converter skips a slot
        if (!r.cfg.sleep_select) begin
            if (r.timer == 32'h0000_0000) begin
                n.timer = period - 32'h0000_0001;
                if (!r.conv_run) begin
                    n.conv_run = 1'b1;
                end
            end else begin
                n.timer = r.timer - 32'h0000_0001;
            end
        end
        // Register port
        if (IDX_WR) begin
            n.idx      = IDX_DATA;
            n.phase_lo = 1'b0;
        end else if (XFER_START) begin
            n.phase_lo = 1'b0;
        end else if (WR_STB) begin
            if (!r.phase_lo) begin
                n.wr_hold  = WR_DATA;
                n.phase_lo = 1'b1;
            end else begin
                n.phase_lo = 1'b0;
                case (r.idx)
                    `TSA_IDX_CONFIG: begin
                        n.cfg.fault_count_field  = word_wr[`TSA_CFG_CF_LO+1:`TSA_CFG_CF_LO];
                        n.cfg.alert_level_select = word_wr[`TSA_CFG_POL];
                        n.cfg.latch_mode_sel     = word_wr[`TSA_CFG_IM];
                        n.cfg.sleep_select       = word_wr[`TSA_CFG_SM];
                        n.cfg.conv_rate          = word_wr[`TSA_CFG_CR_LO+1:`TSA_CFG_CR_LO];
                        if (word_wr[`TSA_CFG_SM]) begin
                            if (!r.cfg.sleep_select) begin
                                n.sleep_fresh = 1'b1;
                            end
                            if (!r.conv_single) begin
                                n.conv_run = 1'b0;
                            end
                            if (r.cfg.latch_mode_sel && r.ph == PH_HOLD_HIGH) begin
                                n.ph = PH_WATCH_LOW;
                            end else if (r.cfg.latch_mode_sel && r.ph == PH_HOLD_LOW) begin
                                n.ph = PH_WATCH_HIGH;
                            end
                        end else if (r.cfg.sleep_select) begin
                            n.timer = 32'h0000_0000;
                        end
                        if (word_wr[`TSA_CFG_SS] && word_wr[`TSA_CFG_SM] && !r.conv_run) begin
                            n.conv_run    = 1'b1;
                            n.conv_single = 1'b1;
                            n.conv_long   = n.sleep_fresh;
                            n.sleep_fresh = 1'b0;
                        end
                        if (r.cfg.latch_mode_sel && !word_wr[`TSA_CFG_IM]) begin
                            n.ph = PH_WATCH_HIGH;
                        end
                    end
                    `TSA_IDX_LOWER: n.lower = word_wr & `TSA_LIMIT_MASK;
                    `TSA_IDX_UPPER: n.upper = word_wr & `TSA_LIMIT_MASK;
                    default: n.phase_lo = 1'b0;
                endcase
            end
        end else if (RD_STB) begin
            if (!r.phase_lo) begin
                n.rd_data  = word_rd[15:8];
                n.rd_hold  = word_rd[7:0];
                n.phase_lo = 1'b1;
            end else begin
                n.rd_data  = r.rd_hold;
                n.phase_lo = 1'b0;
            end
            if (r.cfg.latch_mode_sel && r.ph == PH_HOLD_HIGH) begin
                n.ph = PH_WATCH_LOW;
            end else if (r.cfg.latch_mode_sel && r.ph == PH_HOLD_LOW) begin
                n.ph = PH_WATCH_HIGH;
            end
        end
        // Alert engine; a new fault outranks a clear in the same cycle
        if (fire) begin
            case (r.ph)
                PH_WATCH_HIGH: n.ph = PH_HOLD_HIGH;
                PH_HOLD_HIGH:  n.ph = PH_WATCH_HIGH;
                PH_WATCH_LOW:  n.ph = PH_HOLD_LOW;
                PH_HOLD_LOW:   n.ph = PH_HOLD_LOW;
                default:       n.ph = PH_WATCH_HIGH;
            endcase
        end
        if ((n.ph == PH_HOLD_HIGH) || (n.ph == PH_HOLD_LOW)) begin
            n.alert_pin = n.cfg.alert_level_select;
        end else begin
            n.alert_pin = !n.cfg.alert_level_select;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            r <= CORE_RST;
        end else begin
            r <= n;
        end
    end

    assign RD_DATA   = r.rd_data;
    assign CONV_RUN  = r.conv_run;
    assign CONV_LONG = r.conv_long;
    assign ALERT     = r.alert_pin;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_shot_req;
        cfg_commit && word_wr[`TSA_CFG_SS] && word_wr[`TSA_CFG_SM] && !r.conv_run;
    endsequence

    sequence s_shot_running;
        r.conv_run && r.conv_single;
    endsequence

    property p_shot_needs_sleep;
        @(posedge CLK) disable iff (!RESET_N)
        (cfg_commit && !word_wr[`TSA_CFG_SM] && !r.conv_single) |=> !r.conv_single;
    endproperty
    a_shot_needs_sleep: assert property (p_shot_needs_sleep) else $error("one-shot taken outside sleep");

    property p_shot_start;
        @(posedge CLK) disable iff (!RESET_N)
        s_shot_req |=> s_shot_running ##0 (word_rd[`TSA_CFG_SS] || r.idx != `TSA_IDX_CONFIG);
    endproperty
    a_shot_start: assert property (p_shot_start) else $error("one-shot did not start");

    property p_shot_end;
        @(posedge CLK) disable iff (!RESET_N)
        (s_shot_running ##0 done_rise ##0 !cfg_commit) |=> (!r.conv_single && !CONV_RUN && r.cfg.sleep_select);
    endproperty
    a_shot_end: assert property (p_shot_end) else $error("one-shot did not end");

    property p_first_long;
        @(posedge CLK) disable iff (!RESET_N)
        (s_shot_req ##0 !r.cfg.sleep_select) |=> CONV_LONG;
    endproperty
    a_first_long: assert property (p_first_long) else $error("first sleep conversion not long");

    property p_read_clears;
        @(posedge CLK) disable iff (!RESET_N)
        (RD_STB && !IDX_WR && !XFER_START && !WR_STB && r.cfg.latch_mode_sel && active_r && !fire)
            |=> (ALERT == !r.cfg.alert_level_select);
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear alert");

    property p_pin_polarity;
        @(posedge CLK) disable iff (!RESET_N)
        ##1 (ALERT == (active_r ? r.cfg.alert_level_select : !r.cfg.alert_level_select));
    endproperty
    a_pin_polarity: assert property (p_pin_polarity) else $error("alert level mismatch");

    property p_limit_low_zero;
        @(posedge CLK) disable iff (!RESET_N)
        (r.lower[3:0] == 4'h0) && (r.upper[3:0] == 4'h0);
    endproperty
    a_limit_low_zero: assert property (p_limit_low_zero) else $error("limit low bits not zero");

    property p_temp_only_on_done;
        @(posedge CLK) disable iff (!RESET_N)
        (r.temp != $past(r.temp)) |-> $past(eval);
    endproperty
    a_temp_only_on_done: assert property (p_temp_only_on_done) else $error("reading changed without result");

    property p_byte_order;
        @(posedge CLK) disable iff (!RESET_N)
        (RD_STB && !IDX_WR && !XFER_START && !WR_STB && !r.phase_lo)
            |=> (RD_DATA == $past(word_rd[15:8])) && r.phase_lo;
    endproperty
    a_byte_order: assert property (p_byte_order) else $error("high byte not first");

    property p_cmp_raise;
        @(posedge CLK) disable iff (!RESET_N)
        (fire && r.ph == PH_WATCH_HIGH) |=> (r.ph == PH_HOLD_HIGH) && (ALERT == r.cfg.alert_level_select);
    endproperty
    a_cmp_raise: assert property (p_cmp_raise) else $error("alert did not raise");

endmodule : temp_threshold_alert

// ==== bench/conv_model.sv ====
/*
 * Behavioural converter on the far side of the conversion link.
 * Assumes CONV_RUN comes from the block and that its own 400 ns clock
 * has no phase relation to the block clock.
 */
`timescale 1ns/10ps
module conv_model (
    input  wire logic        CONV_RUN,
    input  wire logic [15:0] VALUE,
    output logic             CONV_DONE,
    output logic [15:0]      CONV_RESULT
);
    logic lclk = 1'b0;

    // ****************************************************************
    // Link clock, deliberately offset from the block clock
    // ****************************************************************
    initial begin
        #37;
        forever #200 lclk = ~lclk;
    end

    // ****************************************************************
    // One result per request; aborted requests give nothing
    // ****************************************************************
    initial begin
        CONV_DONE = 1'b0;
        CONV_RESULT = 16'h5a5a;
        forever begin
            @(posedge lclk iff CONV_RUN);
            repeat (3) @(posedge lclk);
            if (CONV_RUN) begin
                CONV_RESULT = VALUE;
                @(posedge lclk);
                CONV_DONE = 1'b1;
                wait (!CONV_RUN);
                @(posedge lclk);
                CONV_DONE = 1'b0;
                // Stale result must not look valid
                CONV_RESULT = ~VALUE;
            end
        end
    end
endmodule : conv_model

// ==== bench/temp_threshold_alert_bench.sv ====
/*
 * Self-checking bench: register port tasks and scenario sequence.
 * Assumes conv_model answers conversions and a short base period.
 */
`timescale 1ns/10ps
`include "tsa_defines.svh"
module temp_threshold_alert_bench;
    logic        clk = 1'b0, reset_n = 1'b0, idx_wr = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, xfer = 1'b0;
    logic [1:0]  idx_data = 2'h0;
    logic [7:0]  wr_data = 8'h00, rd_data;
    logic        conv_done, conv_run, conv_long, alert;
    logic [15:0] conv_result, word, value = 16'h1234;
    int          miscompares = 0, checks_done = 0, cycles = 0;

    always #25 clk = ~clk;

    temp_threshold_alert #(.BASE_PERIOD_CYC(200)) dut (.CLK(clk), .RESET_N(reset_n), .IDX_WR(idx_wr),
        .IDX_DATA(idx_data), .XFER_START(xfer), .WR_STB(wr_stb), .WR_DATA(wr_data), .RD_STB(rd_stb),
        .RD_DATA(rd_data), .CONV_DONE(conv_done), .CONV_RESULT(conv_result), .CONV_RUN(conv_run),
        .CONV_LONG(conv_long), .ALERT(alert));
    conv_model conv (.CONV_RUN(conv_run), .VALUE(value), .CONV_DONE(conv_done), .CONV_RESULT(conv_result));

    // ****************************************************************
    // Register port tasks, all entered at a falling edge
    // ****************************************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic set_idx(input logic [1:0] i);
        idx_wr = 1'b1;
        idx_data = i;
        @(negedge clk);
        idx_wr = 1'b0;
    endtask : set_idx

    task automatic wr16(input logic [1:0] i, input logic [15:0] v);
        set_idx(i);
        wr_stb = 1'b1;
        wr_data = v[15:8];
        @(negedge clk);
        wr_data = v[7:0];
        @(negedge clk);
        wr_stb = 1'b0;
        repeat (2) @(negedge clk);
    endtask : wr16

    task automatic rd16(input logic [1:0] i, output logic [15:0] w);
        set_idx(i);
        for (int b = 1; b >= 0; b--) begin
            rd_stb = 1'b1;
            @(negedge clk);
            rd_stb = 1'b0;
            repeat (2) @(negedge clk);
            w[8*b +: 8] = rd_data;
        end
    endtask : rd16

    task automatic rdchk(input logic [1:0] i, input logic [15:0] exp);
        logic [15:0] w;
        rd16(i, w);
        check(w, exp);
    endtask : rdchk

    // Waits for one whole conversion, then lets the result land
    task automatic wait_conv;
        int n;
        n = 0;
        while (conv_run !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        while (conv_run !== 1'b0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        // A stalled converter must not slip through as a pass
        if (n >= 2000) begin
            miscompares++;
            $display("[ERR] %0t conversion wait timed out", $time);
        end
        repeat (3) @(negedge clk);
    endtask : wait_conv

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    always @(negedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up;
        end
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        rdchk(2'h0, `TSA_TEMP_RST);
        rdchk(2'h2, `TSA_LOWER_RST);
        rdchk(2'h3, `TSA_UPPER_RST);
        check(alert, 1'b1);
        wait_conv;
        rdchk(2'h0, 16'h1234);
        wr16(2'h0, 16'h7777);
        rdchk(2'h0, 16'h1234);
        wr16(2'h2, 16'h123f);
        rdchk(2'h2, 16'h1230);
        wr16(2'h3, 16'h1000);
        wr16(2'h2, 16'h0800);
        wr16(2'h1, 16'h0880);
        value = 16'h1000;
        wait_conv;
        check(alert, 1'b1);
        wait_conv;
        check(alert, 1'b0);
        value = 16'h0800;
        wait_conv;
        check(alert, 1'b0);
        wait_conv;
        check(alert, 1'b1);
        wr16(2'h1, 16'h0680);
        value = 16'h1000;
        wait_conv;
        check(alert, 1'b1);
        rdchk(2'h2, 16'h0800);
        check(alert, 1'b0);
        value = 16'hfc00;
        wait_conv;
        check(alert, 1'b1);
        wr16(2'h1, 16'h0780);
        check({alert, conv_run}, 2'b00);
        repeat (600) @(negedge clk);
        check(conv_run, 1'b0);
        wr16(2'h1, 16'h8180);
        check(alert, 1'b1);
        check({conv_run, conv_long}, 2'b11);
        rd16(2'h1, word);
        check(word[15], 1'b1);
        wait_conv;
        rd16(2'h1, word);
        check({word[15], conv_run}, 2'b00);
        value = 16'hec00;
        wr16(2'h1, 16'h8180);
        check({conv_run, conv_long}, 2'b10);
        wait_conv;
        rdchk(2'h0, 16'hec00);
        wr16(2'h1, 16'h8080);
        rd16(2'h1, word);
        check({word[15], conv_run}, 2'b01);
        // Lone first byte dropped at a start condition
        set_idx(2'h3);
        wr_stb = 1'b1;
        wr_data = 8'h55;
        @(negedge clk);
        wr_stb = 1'b0;
        xfer = 1'b1;
        @(negedge clk);
        xfer = 1'b0;
        wr_stb = 1'b1;
        wr_data = 8'h0a;
        @(negedge clk);
        wr_data = 8'h5f;
        @(negedge clk);
        wr_stb = 1'b0;
        rdchk(2'h3, 16'h0a50);
        // Sleep entry and one-shot in one word
        wait_conv;
        wr16(2'h1, 16'h8180);
        check({conv_run, conv_long}, 2'b11);
        wrap_up;
    end
endmodule : temp_threshold_alert_bench
